// file: pilot_pkg.sv
package pilot_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] timer_off = 8'h04;
    localparam logic [7:0] status_off = 8'h08;
    localparam logic [7:0] inputs_off = 8'h0C;

    localparam int ctrl_enable_pos = 0;
    localparam int ctrl_gnd_mode_pos = 1;
    localparam int ctrl_start_sel_pos = 3;
    localparam int ctrl_restraint_pos = 5;
    localparam int ctrl_cc_map_pos = 8;
    localparam logic [31:0] ctrl_reset = 32'h0000_E401;
    localparam logic [15:0] coord_ms_reset = 16'h0008;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int clk_mhz = 50;
    localparam int tick_us = 1000;
    localparam int tick_cycles = clk_mhz * tick_us;
    localparam int persist_ms = 25;
    localparam int extend_ms = 30;
    localparam int transient_ms = 30;

    // restraint factor encodings: 0.0 and 0.066
    localparam logic restraint_none = 1'b0;
    localparam logic restraint_pos_seq = 1'b1;

    typedef enum logic [1:0] {
        gnd_distance,
        gnd_dir_overcurrent,
        gnd_both
    } gnd_mode_t;

    typedef enum logic [1:0] {
        start_dir,
        start_zero_seq,
        start_disturbance
    } start_sel_t;

    // measuring function outputs, all active high
    typedef struct packed {
        logic overreach_phase_trip;
        logic overreach_gnd_dist_trip;
        logic gnd_dir_trip;
        logic zone4_phase_block;
        logic zone4_gnd_block;
        logic gnd_dir_block;
        logic zero_seq_start_detector;
        logic zero_seq_restrained;
        logic negative_directional_block;
        logic disturbance_detector;
        logic out_of_step_block;
    } meas_t;

    typedef struct packed {
        logic carrier_start;
        logic carrier_stop;
        logic pilot_trip;
    } outs_t;

endpackage

// file: blocking_pilot_trip_logic.sv
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module blocking_pilot_trip_logic (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire pilot_pkg::meas_t meas,
    input wire logic [3:0] converter_in,
    output logic zone4_reverse,
    output pilot_pkg::outs_t outs
);

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    logic [31:0] ctrl;
    logic [15:0] coord_ms;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire wr_ctrl = do_write && (aw_addr == pilot_pkg::ctrl_off);
    wire wr_timer = do_write && (aw_addr == pilot_pkg::timer_off);
    wire wr_known = wr_ctrl || wr_timer;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (s_axi_awvalid && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && !w_held) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= pilot_pkg::ctrl_reset;
            coord_ms <= pilot_pkg::coord_ms_reset;
        end else begin
            if (wr_ctrl) begin
                ctrl <= merge(ctrl, w_data, w_strb);
            end
            if (wr_timer) begin
                coord_ms <= 16'(merge({16'h0000, coord_ms}, w_data, w_strb));
            end
        end
    end

    // ----------------------------------------------------------------
    // settings
    // ----------------------------------------------------------------
    wire scheme_enable = ctrl[pilot_pkg::ctrl_enable_pos];
    wire [1:0] gnd_mode = ctrl[pilot_pkg::ctrl_gnd_mode_pos +: 2];
    wire [1:0] start_sel = ctrl[pilot_pkg::ctrl_start_sel_pos +: 2];
    wire restraint_factor = ctrl[pilot_pkg::ctrl_restraint_pos];
    wire [7:0] cc_map = ctrl[pilot_pkg::ctrl_cc_map_pos +: 8];

    // ----------------------------------------------------------------
    // converter inputs, from contacts outside the clock domain
    // ----------------------------------------------------------------
    logic [3:0] cc_meta;
    logic [3:0] cc_sync;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cc_meta <= 4'h0;
            cc_sync <= 4'h0;
        end else begin
            cc_meta <= converter_in;
            cc_sync <= cc_meta;
        end
    end

    // each function picks its converter by a 2-bit index
    wire receiver_converter = cc_sync[cc_map[1:0]];
    wire second_receiver_converter = cc_sync[cc_map[3:2]];
    wire carrier_halt_converter = cc_sync[cc_map[5:4]];
    wire pilot_inhibit_converter = cc_sync[cc_map[7:6]];

    // ----------------------------------------------------------------
    // millisecond tick
    // ----------------------------------------------------------------
    logic [15:0] tick_cnt;
    logic ms_tick;
    wire tick_wrap = (tick_cnt == 16'(pilot_pkg::tick_cycles - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt <= 16'h0000;
            ms_tick <= 1'b0;
        end else begin
            ms_tick <= tick_wrap;
            tick_cnt <= tick_wrap ? 16'h0000 : tick_cnt + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // trip and block functions
    // ----------------------------------------------------------------
    wire use_dist = (gnd_mode != 2'(pilot_pkg::gnd_dir_overcurrent));
    wire use_ground_dir_overcurrent = (gnd_mode != 2'(pilot_pkg::gnd_distance));
    wire zero_seq = (restraint_factor == pilot_pkg::restraint_pos_seq)
        ? meas.zero_seq_restrained : meas.zero_seq_start_detector;

    wire overreach_trip = scheme_enable && (meas.overreach_phase_trip
        || (use_dist && meas.overreach_gnd_dist_trip)
        || (use_ground_dir_overcurrent && meas.gnd_dir_trip));

    // trip functions win over blockers, so blockers are inhibited
    wire dist_block_raw = !overreach_trip && (meas.zone4_phase_block
        || (use_dist && meas.zone4_gnd_block));
    wire ground_dir_overcurrent_block_raw = !overreach_trip && use_ground_dir_overcurrent && meas.gnd_dir_block;

    logic gnd_start;
    always_comb begin
        case (start_sel)
            2'(pilot_pkg::start_dir): gnd_start = zero_seq && meas.negative_directional_block;
            2'(pilot_pkg::start_zero_seq): gnd_start = zero_seq;
            default: gnd_start = meas.disturbance_detector;
        endcase
    end

    // ----------------------------------------------------------------
    // transient blocking timers
    // ----------------------------------------------------------------
    logic [4:0] persist_cnt;
    logic ground_dir_persistence_timer;
    logic [4:0] ground_dir_overcurrent_ext_cnt;
    logic [4:0] dist_ext_cnt;

    function automatic logic [4:0] ms_to5(input int ms);
        return 5'(ms);
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            persist_cnt <= 5'h00;
            ground_dir_persistence_timer <= 1'b0;
            ground_dir_overcurrent_ext_cnt <= 5'h00;
            dist_ext_cnt <= 5'h00;
        end else begin
            // trip drops the whole chain, so internal faults never reach it
            if (!ground_dir_overcurrent_block_raw) begin
                persist_cnt <= 5'h00;
            end else if (ms_tick && persist_cnt != ms_to5(pilot_pkg::persist_ms)) begin
                persist_cnt <= persist_cnt + 5'h01;
            end
            if (ground_dir_overcurrent_block_raw && persist_cnt == ms_to5(pilot_pkg::persist_ms)) begin
                ground_dir_persistence_timer <= 1'b1;
            end else if (overreach_trip || ground_dir_overcurrent_ext_cnt == 5'h01 && ms_tick) begin
                ground_dir_persistence_timer <= 1'b0;
            end
            // one spare ms makes the dropout at least the figure
            if (overreach_trip) begin
                ground_dir_overcurrent_ext_cnt <= 5'h00;
            end else if (ground_dir_overcurrent_block_raw && ground_dir_persistence_timer) begin
                ground_dir_overcurrent_ext_cnt <= ms_to5(pilot_pkg::extend_ms + 1);
            end else if (ms_tick && ground_dir_overcurrent_ext_cnt != 5'h00) begin
                ground_dir_overcurrent_ext_cnt <= ground_dir_overcurrent_ext_cnt - 5'h01;
            end
            if (overreach_trip) begin
                dist_ext_cnt <= 5'h00;
            end else if (dist_block_raw) begin
                dist_ext_cnt <= ms_to5(pilot_pkg::transient_ms + 1);
            end else if (ms_tick && dist_ext_cnt != 5'h00) begin
                dist_ext_cnt <= dist_ext_cnt - 5'h01;
            end
        end
    end

    wire ground_dir_overcurrent_block = ground_dir_overcurrent_block_raw || ground_dir_overcurrent_ext_cnt != 5'h00;
    wire dist_block = dist_block_raw || dist_ext_cnt != 5'h00;
    wire local_block = scheme_enable && (ground_dir_overcurrent_block || dist_block);

    // ----------------------------------------------------------------
    // carrier control and comparer
    // ----------------------------------------------------------------
    wire pilot_active = scheme_enable && !pilot_inhibit_converter;
    wire key_request = !overreach_trip && (local_block
        || (scheme_enable && use_ground_dir_overcurrent && gnd_start));
    wire carrier_on = pilot_active && key_request && !carrier_halt_converter;
    wire received_block = receiver_converter || second_receiver_converter;
    wire trip_comparer = pilot_active && overreach_trip && !received_block
        && !local_block && !meas.out_of_step_block;

    logic [15:0] coord_ms_cnt;
    logic coordination_timer;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            coord_ms_cnt <= 16'h0000;
            coordination_timer <= 1'b0;
            outs <= '0;
        end else begin
            if (!trip_comparer) begin
                coord_ms_cnt <= 16'h0000;
                coordination_timer <= 1'b0;
            end else if (coord_ms_cnt >= coord_ms) begin
                coordination_timer <= 1'b1;
            end else if (ms_tick) begin
                coord_ms_cnt <= coord_ms_cnt + 16'h0001;
            end
            outs.pilot_trip <= trip_comparer && coordination_timer
                && meas.disturbance_detector;
            outs.carrier_start <= carrier_on;
            outs.carrier_stop <= !carrier_on;
        end
    end
    assign zone4_reverse = scheme_enable;

    // ----------------------------------------------------------------
    // status read
    // ----------------------------------------------------------------
    wire [31:0] rd_mux = (s_axi_araddr[7:0] == pilot_pkg::ctrl_off) ? ctrl
        : (s_axi_araddr[7:0] == pilot_pkg::timer_off) ? {16'h0000, coord_ms}
        : (s_axi_araddr[7:0] == pilot_pkg::status_off)
            ? {25'h0, coordination_timer, ground_dir_persistence_timer,
               local_block, pilot_active, outs}
        : (s_axi_araddr[7:0] == pilot_pkg::inputs_off) ? {28'h0000000, cc_sync}
        : 32'h0000_0000;
    wire rd_known = (s_axi_araddr[7:0] == pilot_pkg::ctrl_off)
        || (s_axi_araddr[7:0] == pilot_pkg::timer_off)
        || (s_axi_araddr[7:0] == pilot_pkg::status_off)
        || (s_axi_araddr[7:0] == pilot_pkg::inputs_off);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_known ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_trip_needs_fd;
        @(posedge aclk) disable iff (!aresetn)
        outs.pilot_trip |-> $past(meas.disturbance_detector);
    endproperty
    a_trip_needs_fd: assert property (p_trip_needs_fd) else $error("trip without fd");
    property p_rx_blocks;
        @(posedge aclk) disable iff (!aresetn)
        received_block |=> !outs.pilot_trip;
    endproperty
    a_rx_blocks: assert property (p_rx_blocks) else $error("trip under rx block");
    property p_local_blocks;
        @(posedge aclk) disable iff (!aresetn)
        local_block |=> !outs.pilot_trip;
    endproperty
    a_local_blocks: assert property (p_local_blocks) else $error("trip under local block");
    property p_halt_stops;
        @(posedge aclk) disable iff (!aresetn)
        carrier_halt_converter |=> outs.carrier_stop && !outs.carrier_start;
    endproperty
    a_halt_stops: assert property (p_halt_stops) else $error("carrier on during halt");
    property p_inhibit;
        @(posedge aclk) disable iff (!aresetn)
        pilot_inhibit_converter |=> !outs.pilot_trip && !outs.carrier_start;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("pilot active while inhibited");
    property p_trip_stops_carrier;
        @(posedge aclk) disable iff (!aresetn)
        overreach_trip |=> !outs.carrier_start;
    endproperty
    a_trip_stops_carrier: assert property (p_trip_stops_carrier) else $error("carrier on");
    property p_no_persist_on_trip;
        @(posedge aclk) disable iff (!aresetn)
        overreach_trip |=> !ground_dir_persistence_timer;
    endproperty
    a_no_persist_on_trip: assert property (p_no_persist_on_trip) else $error("persist");
    property p_start_stop_exclusive;
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> outs.carrier_start != outs.carrier_stop;
    endproperty
    a_start_stop_exclusive: assert property (p_start_stop_exclusive) else $error("same");
    sequence s_delay_armed;
        trip_comparer && !coordination_timer;
    endsequence
    property p_coord_delay;
        @(posedge aclk) disable iff (!aresetn)
        s_delay_armed |=> !outs.pilot_trip;
    endproperty
    a_coord_delay: assert property (p_coord_delay) else $error("trip before delay");

endmodule

// file: carrier_set_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// far-end carrier set: keyed by start, unkeyed by stop
// ----------------------------------------------------------------
module carrier_set_model (
    input wire logic aclk,
    input wire logic carrier_start,
    input wire logic carrier_stop,
    input wire logic remote_key,
    input wire logic [3:0] lag,
    output logic keyed,
    output logic rx_out
);
    logic [15:0] line_delay;

    initial keyed = 1'b0;
    initial line_delay = 16'h0000;

    always @(posedge aclk) begin
        if (carrier_start) begin
            keyed <= 1'b1;
        end else if (carrier_stop) begin
            keyed <= 1'b0;
        end
        line_delay <= {line_delay[14:0], remote_key};
    end

    // a slow channel shows the remote block only after lag + 1 cycles
    assign rx_out = line_delay[lag];
endmodule

// file: blocking_pilot_trip_logic_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module blocking_pilot_trip_logic_tb;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, zone4_reverse, remote_key, keyed, rx_out;
    logic [31:0] awaddr, wdata, araddr, rdata, rd, rv;
    logic [3:0] wstrb, conv, lag;
    logic [1:0] bresp, rresp, resp;
    logic got;
    pilot_pkg::meas_t meas;
    pilot_pkg::outs_t outs;
    integer seed;
    int bad_count, total_checks;

    blocking_pilot_trip_logic u_blocking_pilot_trip_logic (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .meas(meas),
        .converter_in({conv[3:1], rx_out}), .zone4_reverse(zone4_reverse), .outs(outs));

    carrier_set_model u_carrier_set_model (.aclk(aclk), .carrier_start(outs.carrier_start),
        .carrier_stop(outs.carrier_stop), .remote_key(remote_key), .lag(lag),
        .keyed(keyed), .rx_out(rx_out));

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // ----------------------------------------------------------------
    // closing, bus and expectation helpers
    // ----------------------------------------------------------------
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= {24'h000000, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
            end
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic bus_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= {24'h000000, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
            end
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // wait in whole cycles, then look once outputs have settled
    task automatic look(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask

    task automatic wait_trip(input logic v, input int lim);
        int n;
        n = 0;
        got = outs.pilot_trip;
        while (got !== v && n < lim) begin
            look(1);
            got = outs.pilot_trip;
            n++;
        end
    endtask

    function automatic logic [31:0] ctrl_word(input logic en, input logic [1:0] gnd,
                                              input logic [1:0] sel, input logic rf);
        ctrl_word = {16'h0000, 8'hE4, 2'h0, rf, sel, gnd, en};
    endfunction

    function automatic logic exp_start(input logic [1:0] sel, input int p);
        case (sel)
            2'h0: exp_start = (p == 1);
            2'h1: exp_start = (p != 2);
            default: exp_start = (p == 2);
        endcase
    endfunction

    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        wrap_up();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 32'h2cb9;
        {aresetn, awvalid, wvalid, bready, arvalid, rready, remote_key} = 7'h00;
        {awaddr, wdata, araddr} = {32'h0, 32'h0, 32'h0};
        wstrb = 4'hF;
        conv = 4'h0;
        lag = 4'h1;
        meas = '0;
        look(5);
        `CHK("outs_in_reset", 3'h0, outs)
        @(posedge aclk);
        aresetn <= 1'b1;
        look(2);
        `CHK("stop_idle", 1'b1, outs.carrier_stop)
        `CHK("zone4_rev", 1'b1, zone4_reverse)
        bus_read(pilot_pkg::ctrl_off, rd, resp);
        `CHK("ctrl_reset", pilot_pkg::ctrl_reset, rd)
        bus_read(pilot_pkg::timer_off, rd, resp);
        `CHK("coord_reset", pilot_pkg::coord_ms_reset, rd[15:0])
        bus_read(8'h10, rd, resp);
        `CHK("unmapped_rresp", 2'h2, resp)
        `CHK("unmapped_rdata", 32'h0, rd)
        rv = $random(seed);
        bus_write(8'h14, rv, resp);
        `CHK("unmapped_bresp", 2'h2, resp)
        bus_write(pilot_pkg::timer_off, {16'h0000, rv[15:0]}, resp);
        bus_read(pilot_pkg::timer_off, rd, resp);
        `CHK("coord_rw", rv[15:0], rd[15:0])
        bus_write(pilot_pkg::ctrl_off, ctrl_word(1'b0, 2'h0, 2'h0, 1'b0), resp);
        look(1);
        `CHK("zone4_rev_off", 1'b0, zone4_reverse)
        // every start source against every stimulus pattern
        for (int s = 0; s < 3; s++) begin
            bus_write(pilot_pkg::ctrl_off, ctrl_word(1'b1, 2'h1, s[1:0], 1'b0), resp);
            for (int p = 0; p < 3; p++) begin
                @(posedge aclk);
                meas.zero_seq_start_detector <= (p != 2);
                meas.negative_directional_block <= (p == 1);
                meas.disturbance_detector <= (p == 2);
                look(4);
                `CHK("start_sel", exp_start(s[1:0], p), outs.carrier_start)
                @(posedge aclk);
                meas <= '0;
                look(4);
            end
        end
        for (int f = 0; f < 2; f++) begin
            bus_write(pilot_pkg::ctrl_off, ctrl_word(1'b1, 2'h1, 2'h1, f[0]), resp);
            @(posedge aclk);
            meas.zero_seq_restrained <= 1'b1;
            look(4);
            `CHK("restraint", f[0], outs.carrier_start)
            @(posedge aclk);
            meas <= '0;
            look(4);
        end
        // separate ground paths per ground mode
        for (int g = 0; g < 3; g++) begin
            bus_write(pilot_pkg::ctrl_off, ctrl_word(1'b1, g[1:0], 2'h0, 1'b0), resp);
            @(posedge aclk);
            meas.gnd_dir_block <= 1'b1;
            look(4);
            `CHK("ground_dir_overcurrent_block", (g != 0), outs.carrier_start)
            @(posedge aclk);
            meas.gnd_dir_block <= 1'b0;
            meas.zone4_gnd_block <= 1'b1;
            look(4);
            `CHK("gdist_block", (g != 1), outs.carrier_start)
            // a trip pulse clears the 30 ms extension, far too long to wait out
            @(posedge aclk);
            meas.zone4_gnd_block <= 1'b0;
            meas.overreach_phase_trip <= 1'b1;
            @(posedge aclk);
            meas.overreach_phase_trip <= 1'b0;
            look(4);
        end
        bus_write(pilot_pkg::ctrl_off, pilot_pkg::ctrl_reset, resp);
        @(posedge aclk);
        meas.zone4_phase_block <= 1'b1;
        look(4);
        `CHK("block_keys", 1'b1, outs.carrier_start)
        `CHK("stop_opposite", 1'b0, outs.carrier_stop)
        `CHK("set_keyed", 1'b1, keyed)
        for (int c = 2; c < 4; c++) begin
            @(posedge aclk);
            conv[c] <= 1'b1;
            look(6);
            `CHK("halt_inhibit", 1'b0, outs.carrier_start)
            @(posedge aclk);
            conv[c] <= 1'b0;
            look(6);
            `CHK("rekey", 1'b1, outs.carrier_start)
        end
        @(posedge aclk);
        meas.overreach_phase_trip <= 1'b1;
        look(4);
        `CHK("trip_over_block", 1'b0, outs.carrier_start)
        `CHK("set_unkeyed", 1'b0, keyed)
        // trip path with the shortest coordination delay
        bus_write(pilot_pkg::timer_off, 32'h0000_0000, resp);
        @(posedge aclk);
        meas.zone4_phase_block <= 1'b0;
        meas.disturbance_detector <= 1'b1;
        wait_trip(1'b1, 20);
        `CHK("trip", 1'b1, got)
        `CHK("trip_no_carrier", 1'b0, outs.carrier_start)
        @(posedge aclk);
        meas.disturbance_detector <= 1'b0;
        wait_trip(1'b0, 4);
        `CHK("trip_needs_fd", 1'b0, got)
        @(posedge aclk);
        meas.disturbance_detector <= 1'b1;
        wait_trip(1'b1, 4);
        `CHK("trip_back", 1'b1, got)
        @(posedge aclk);
        lag <= 4'hA;
        remote_key <= 1'b1;
        wait_trip(1'b0, 20);
        `CHK("rx_blocks", 1'b0, got)
        @(posedge aclk);
        remote_key <= 1'b0;
        wait_trip(1'b1, 30);
        `CHK("rx_release", 1'b1, got)
        @(posedge aclk);
        conv[1] <= 1'b1;
        wait_trip(1'b0, 8);
        `CHK("second_rx_blocks", 1'b0, got)
        bus_read(pilot_pkg::inputs_off, rd, resp);
        `CHK("second_rx", 1'b1, rd[1])
        wrap_up();
    end
endmodule
